// file: mot_checker_properties.sv
// Purpose: Port-level checks for the main oscillator trim control.
// Assumes: Bound to the top module; one clock domain.
// Notes:   Only outputs the design drives are judged.
`timescale 1ns/1ns
`default_nettype none
module mot_checker
    import mot_pkg::*;
#(
    parameter logic [7:0] FAC5V = MOT_FAC5V_DEFAULT
) (
    input wire logic        CLK,
    input wire logic        RESET,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        XTAL_STABLE,
    input wire logic [7:0]  MAIN_OSC_TRIM_CODE,
    input wire logic        OSC48_TICK,
    input wire logic        OSC24_TICK,
    input wire logic        LOCK_ACTIVE
);
    // Common clock and reset
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    // Answer two cycles after setup, inside an access, one cycle long
    a_ready_latency: assert property (PSEL && !PENABLE |-> ##2 PREADY)
        else $error("ready late");
    a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_reset_code: assert property ($fell(RESET) |-> MAIN_OSC_TRIM_CODE == FAC5V)
        else $error("code not factory value after reset");
    a_fac_read: assert property (PREADY && !PWRITE && PADDR == MOT_OFS_FAC5V
        |-> PRDATA == {MOT_ZERO_WORD[31:8], FAC5V})
        else $error("factory value read wrong");
    a_trim_wo: assert property (PREADY && !PWRITE && PADDR == MOT_OFS_TRIM
        |-> PRDATA == MOT_ZERO_WORD)
        else $error("trim read not zero");
    // fast tick is a single pulse
    a_tick_pulse: assert property (OSC48_TICK |=> !OSC48_TICK)
        else $error("48 MHz tick too long");
    // slow tick follows a fast tick
    a_half_rate: assert property (OSC24_TICK |-> $past(OSC48_TICK))
        else $error("24 MHz tick without 48 MHz tick");
    a_lock_gated: assert property (LOCK_ACTIVE |-> $past(XTAL_STABLE, 2)
        || $past(XTAL_STABLE, 3) || $past(XTAL_STABLE, 4))
        else $error("lock active without stable crystal");
endmodule : mot_checker

bind mot_main_oscillator_trim_ctrl mot_checker #(.FAC5V(FAC5V)) u_chk (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .XTAL_STABLE(XTAL_STABLE), .MAIN_OSC_TRIM_CODE(MAIN_OSC_TRIM_CODE),
    .OSC48_TICK(OSC48_TICK), .OSC24_TICK(OSC24_TICK), .LOCK_ACTIVE(LOCK_ACTIVE)
);
`default_nettype wire

// file: mot_fac_if.sv
// Purpose: Carrier between the control logic and the factory trim store.
// Assumes: Read data appear one clock after the select.
// Notes:   Select chooses the 5.0V or 3.3V value.
`timescale 1ns/1ns
`default_nettype none
interface mot_fac_if;
    logic       sel;
    logic [7:0] value;

    modport store (input sel, output value);
    modport user  (output sel, input value);
endinterface : mot_fac_if
`default_nettype wire

// file: mot_factory_rom.sv
// Purpose: Holds the two factory trim values and returns one per request.
// Assumes: Values are fixed at build time.
// Notes:   Read data come from a register, one clock after the select.
`timescale 1ns/1ns
`default_nettype none
module mot_factory_rom
    import mot_pkg::*;
#(
    parameter logic [7:0] FAC5V = MOT_FAC5V_DEFAULT,
    parameter logic [7:0] FAC3V = MOT_FAC3V_DEFAULT
) (
    input  wire logic CLK,
    input  wire logic RESET,
    mot_fac_if.store  fac
);
    typedef struct packed {
        logic [7:0] value;
    } mot_rom_t;

    mot_rom_t s_r;
    mot_rom_t s_nxt;

    // Select one of the two stored values
    always_comb begin
        s_nxt = s_r;
        s_nxt.value = (fac.sel == MOT_SEL_3V) ? FAC3V : FAC5V;
    end

    // Registered read port
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign fac.value = s_r.value;
endmodule : mot_factory_rom
`default_nettype wire

// file: mot_main_oscillator_trim_ctrl.sv
// Purpose: APB-controlled trim, tick generator and crystal lock of the main oscillator.
// Assumes: XTAL_REF and XTAL_STABLE come from outside and are synchronised here.
// Notes:   Ticks are enable pulses at a scaled rate; trim code drives the analog core.
`timescale 1ns/1ns
`default_nettype none
module mot_main_oscillator_trim_ctrl
    import mot_pkg::*;
#(
    parameter logic [7:0]  FAC5V       = MOT_FAC5V_DEFAULT,
    parameter logic [7:0]  FAC3V       = MOT_FAC3V_DEFAULT,
    parameter logic [15:0] LOCK_TARGET = MOT_LOCK_TARGET
) (
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    input  wire logic        XTAL_REF,
    input  wire logic        XTAL_STABLE,
    output var  logic [7:0]  MAIN_OSC_TRIM_CODE,
    output var  logic        OSC48_TICK,
    output var  logic        OSC24_TICK,
    output var  logic        LOCK_ACTIVE
);
    typedef struct packed {
        mot_state_t  state;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [7:0]  main_osc_freq_trim;
        logic        lock_en;
        logic        xs_meta;
        logic        xs_sync;
        logic        xr_meta;
        logic        xr_sync;
        logic        xr_prev;
        logic [15:0] phase;
        logic        tick48;
        logic        tick24;
        logic        half;
        logic [15:0] cnt;
        logic [15:0] last_cnt;
        logic [7:0]  corr;
        logic [7:0]  code;
        logic        locked;
    } mot_ctl_t;

    mot_ctl_t s_r;
    mot_ctl_t s_nxt;

    mot_fac_if fac ();

    mot_factory_rom #(
        .FAC5V (FAC5V),
        .FAC3V (FAC3V)
    ) u_rom (
        .CLK   (CLK),
        .RESET (RESET),
        .fac   (fac)
    );

    // Add a signed offset to an unsigned code, clamped to 0..255
    function automatic logic [7:0] mot_sat_add(input logic [7:0] base,
                                               input logic [7:0] delta);
        logic [9:0] sum;
        sum = {2'b00, base} + {{2{delta[7]}}, delta};
        if (sum[9]) begin
            mot_sat_add = 8'h00;
        end else if (sum[8]) begin
            mot_sat_add = 8'hFF;
        end else begin
            mot_sat_add = sum[7:0];
        end
    endfunction : mot_sat_add

    // Factory select follows the bus address
    assign fac.sel = (PADDR == MOT_OFS_FAC3V) ? MOT_SEL_3V : MOT_SEL_5V;

    // Next state of all control
    always_comb begin
        logic        wr_now;
        logic        rise;
        logic [15:0] sum;
        wr_now = 1'b0;
        rise   = 1'b0;
        sum    = 16'h0000;
        s_nxt  = s_r;

        // APB handshake: one wait state, PREADY high in the second access cycle
        case (s_r.state)
            MOT_ST_IDLE: begin
                s_nxt.pready  = 1'b0;
                s_nxt.pslverr = 1'b0;
                if (PSEL && !PENABLE) begin
                    s_nxt.state = MOT_ST_ACC;
                end
            end
            MOT_ST_ACC: begin
                s_nxt.state   = MOT_ST_RESP;
                s_nxt.pready  = 1'b1;
                s_nxt.prdata  = MOT_ZERO_WORD;
                s_nxt.pslverr = 1'b0;
                if (PADDR == MOT_OFS_TRIM) begin
                    s_nxt.prdata = MOT_ZERO_WORD;
                end else if (PADDR == MOT_OFS_FAC5V || PADDR == MOT_OFS_FAC3V) begin
                    s_nxt.prdata = {24'h00_0000, fac.value};
                end else if (PADDR == MOT_OFS_CTRL) begin
                    s_nxt.prdata[MOT_CTRL_LOCK_EN_BIT] = s_r.lock_en;
                end else if (PADDR == MOT_OFS_STATUS) begin
                    s_nxt.prdata = {s_r.last_cnt, s_r.corr, 6'b00_0000,
                                    s_r.xs_sync, s_r.locked};
                end else begin
                    s_nxt.pslverr = 1'b1;
                end
            end
            MOT_ST_RESP: begin
                s_nxt.state   = MOT_ST_IDLE;
                s_nxt.pready  = 1'b0;
                s_nxt.pslverr = 1'b0;
                wr_now        = PSEL && PENABLE && PWRITE && !s_r.pslverr;
            end
            default: begin
                s_nxt.state  = MOT_ST_IDLE;
                s_nxt.pready = 1'b0;
            end
        endcase

        // Register writes take effect at the completing edge
        if (wr_now) begin
            if (PADDR == MOT_OFS_TRIM) begin
                s_nxt.main_osc_freq_trim = PWDATA[7:0];
            end else if (PADDR == MOT_OFS_CTRL) begin
                s_nxt.lock_en = PWDATA[MOT_CTRL_LOCK_EN_BIT];
            end
        end

        // Two-flop synchronisers for the crystal pins
        s_nxt.xs_meta = XTAL_STABLE;
        s_nxt.xs_sync = s_r.xs_meta;
        s_nxt.xr_meta = XTAL_REF;
        s_nxt.xr_sync = s_r.xr_meta;
        s_nxt.xr_prev = s_r.xr_sync;
        rise          = s_r.xr_sync && !s_r.xr_prev;

        s_nxt.locked = s_r.lock_en && s_r.xs_sync;

        // Count 48 MHz ticks per crystal period and steer the correction
        if (!s_r.locked) begin
            s_nxt.cnt  = 16'h0000;
            s_nxt.corr = 8'h00;
        end else if (rise) begin
            s_nxt.last_cnt = s_r.cnt;
            s_nxt.cnt      = 16'h0000;
            if (s_r.cnt > LOCK_TARGET && s_r.corr != 8'h80) begin
                s_nxt.corr = s_r.corr - 8'h01;
            end else if (s_r.cnt < LOCK_TARGET && s_r.corr != 8'h7F) begin
                s_nxt.corr = s_r.corr + 8'h01;
            end
        end else if (s_r.tick48 && s_r.cnt != 16'hFFFF) begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end

        // Effective code is trim plus lock correction
        s_nxt.code = mot_sat_add(s_r.main_osc_freq_trim, s_r.corr);

        sum          = s_r.phase + MOT_NCO_BASE + {8'h00, s_r.code};
        s_nxt.phase  = sum;
        s_nxt.tick48 = (sum < s_r.phase);

        s_nxt.tick24 = 1'b0;
        if (s_r.tick48) begin
            s_nxt.half   = !s_r.half;
            s_nxt.tick24 = s_r.half;
        end
    end

    // State register
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            s_r       <= '0;
            s_r.state <= MOT_ST_IDLE;
            s_r.main_osc_freq_trim <= FAC5V;
            s_r.code  <= FAC5V;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign PRDATA             = s_r.prdata;
    assign PREADY             = s_r.pready;
    assign PSLVERR            = s_r.pslverr;
    assign MAIN_OSC_TRIM_CODE = s_r.code;
    assign OSC48_TICK         = s_r.tick48;
    assign OSC24_TICK         = s_r.tick24;
    assign LOCK_ACTIVE        = s_r.locked;
endmodule : mot_main_oscillator_trim_ctrl
`default_nettype wire

// file: mot_pkg.sv
// Purpose: Shared constants and types for the main oscillator trim control.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Trim and oscillator ticks are modelled at the CLK rate.
// Contract
// - Provide a 48 MHz output and a 24 MHz output at the same time.
// - Every reset loads the trim register with the 5.0V factory value.
// - Hold 5.0V and 3.3V factory trim values; software can read both.
// - Trim register is eight bits, writable, resetting to the factory value.
// - Larger trim code gives higher oscillator frequency, monotonically.
// - Optional mode phase-locks the main oscillator to the external crystal.
package mot_pkg;

    // Register byte offsets
    localparam logic [11:0] MOT_OFS_TRIM    = 12'h000;
    localparam logic [11:0] MOT_OFS_FAC5V   = 12'h004;
    localparam logic [11:0] MOT_OFS_FAC3V   = 12'h008;
    localparam logic [11:0] MOT_OFS_CTRL    = 12'h00C;
    localparam logic [11:0] MOT_OFS_STATUS  = 12'h010;

    // Field positions
    localparam int          MOT_CTRL_LOCK_EN_BIT  = 0;
    localparam int          MOT_STAT_LOCKED_BIT   = 0;
    localparam int          MOT_STAT_XSTABLE_BIT  = 1;

    // Reset and default values
    localparam logic [7:0]  MOT_FAC5V_DEFAULT     = 8'h80;
    localparam logic [7:0]  MOT_FAC3V_DEFAULT     = 8'h70;
    localparam logic [15:0] MOT_NCO_BASE          = 16'h1000;
    localparam logic [15:0] MOT_LOCK_TARGET       = 16'h0100;
    localparam logic [31:0] MOT_ZERO_WORD         = 32'h0000_0000;

    // Factory store selects
    localparam logic        MOT_SEL_5V            = 1'b0;
    localparam logic        MOT_SEL_3V            = 1'b1;

    // Bus handshake states
    typedef enum logic [2:0] {
        MOT_ST_IDLE = 3'b001,
        MOT_ST_ACC  = 3'b010,
        MOT_ST_RESP = 3'b100
    } mot_state_t;

endpackage : mot_pkg

// file: tb_top.sv
// Purpose: Self-checking bench for the main oscillator trim control.
// Assumes: Bench is the APB master; 50 ns clock.
// Notes:   Tick rates are counted over fixed windows.
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import mot_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0, pen = 1'b0, pwrite = 1'b0;
    logic        xref = 1'b0, xstab = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, err, t48, t24, lock;
    logic [7:0]  code;
    int          err_total = 0, comparisons = 0;

    // Clock and free-running crystal reference
    always #25 clk = ~clk;
    always begin
        repeat (7) @(posedge clk);
        xref <= ~xref;
    end

    mot_main_oscillator_trim_ctrl u_dut (
        .CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(pen), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .XTAL_REF(xref), .XTAL_STABLE(xstab),
        .MAIN_OSC_TRIM_CODE(code), .OSC48_TICK(t48), .OSC24_TICK(t24),
        .LOCK_ACTIVE(lock));

    // Final report
    task automatic conclude();
        $display("err_total=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, held until ready, then one idle edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            conclude();
        end
        @(posedge clk);
    endtask : apb

    // Tick counts over 1024 cycles
    task automatic count(output int c48, output int c24);
        repeat (4) @(posedge clk);
        c48 = 0;
        c24 = 0;
        repeat (1024) begin
            @(posedge clk);
            c48 += t48;
            c24 += t24;
        end
    endtask : count

    // Reset values, factory store, refusals
    task automatic t_reset();
        chk(code, MOT_FAC5V_DEFAULT);
        apb(1'b0, MOT_OFS_TRIM, MOT_ZERO_WORD);
        chk(rd, MOT_ZERO_WORD);
        apb(1'b1, MOT_OFS_FAC5V, 32'h0000_0055);
        apb(1'b0, MOT_OFS_FAC5V, MOT_ZERO_WORD);
        chk(rd, {24'h00_0000, MOT_FAC5V_DEFAULT});
        apb(1'b0, MOT_OFS_FAC3V, MOT_ZERO_WORD);
        chk(rd, {24'h00_0000, MOT_FAC3V_DEFAULT});
        apb(1'b0, 12'h020, MOT_ZERO_WORD);
        chk(err, 1'b1);
        $display("test reset done");
    endtask : t_reset

    // Software loads the 3.3V value, reset restores 5.0V
    task automatic t_trim();
        apb(1'b1, MOT_OFS_TRIM, {24'h00_0000, MOT_FAC3V_DEFAULT});
        repeat (4) @(posedge clk);
        chk(code, MOT_FAC3V_DEFAULT);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(code, MOT_FAC5V_DEFAULT);
        $display("test trim done");
    endtask : t_trim

    // Higher code runs faster; slow output is half rate
    task automatic t_rate();
        int lo, hi, l24, h24;
        apb(1'b1, MOT_OFS_TRIM, 32'h0000_0000);
        count(lo, l24);
        apb(1'b1, MOT_OFS_TRIM, 32'h0000_00FF);
        count(hi, h24);
        chk(lo, 1024 * MOT_NCO_BASE / 65536);
        chk(hi > lo + 2, 1'b1);
        chk(2 * h24 >= hi - 1 && 2 * h24 <= hi + 1, 1'b1);
        chk(l24 > 0, 1'b1);
        $display("test rate done");
    endtask : t_rate

    // Lock waits for a stable crystal and clears when off
    task automatic t_lock();
        int n;
        // Hardware gate holds even if enable comes too early
        apb(1'b1, MOT_OFS_CTRL, 32'h0000_0001);
        repeat (8) @(posedge clk);
        chk(lock, 1'b0);
        apb(1'b1, MOT_OFS_CTRL, MOT_ZERO_WORD);
        xstab <= 1'b1;
        n = 0;
        rd = MOT_ZERO_WORD;
        while (rd[MOT_STAT_XSTABLE_BIT] !== 1'b1 && n < 16) begin
            apb(1'b0, MOT_OFS_STATUS, MOT_ZERO_WORD);
            n++;
        end
        if (rd[MOT_STAT_XSTABLE_BIT] !== 1'b1) begin
            err_total++;
            conclude();
        end
        apb(1'b1, MOT_OFS_CTRL, 32'h0000_0001);
        apb(1'b0, MOT_OFS_CTRL, MOT_ZERO_WORD);
        chk(rd, 32'h0000_0001);
        repeat (40) @(posedge clk);
        chk(lock, 1'b1);
        apb(1'b0, MOT_OFS_STATUS, MOT_ZERO_WORD);
        chk(rd[MOT_STAT_XSTABLE_BIT], 1'b1);
        chk(rd[MOT_STAT_LOCKED_BIT], 1'b1);
        // Few ticks per crystal period, far below target: correction must rise
        chk(rd[15:8] > 8'h00 && rd[15:8] < 8'h80, 1'b1);
        apb(1'b1, MOT_OFS_TRIM, 32'h0000_0040);
        apb(1'b1, MOT_OFS_CTRL, 32'h0000_0000);
        repeat (8) @(posedge clk);
        chk(lock, 1'b0);
        chk(code, 8'h40);
        $display("test lock done");
    endtask : t_lock

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_trim();
        t_rate();
        t_lock();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
